//--- verilog/insn_decode_pkg.sv
/*
 Constants and types for the instruction format decoder: APB register
 offsets, format numbers, first-byte patterns and field codes.
 Assumes a 32-bit APB master and a little-endian instruction word.
*/
package insn_decode_pkg;

    // ************************************************************
    // register map (byte addresses)
    // ************************************************************
    localparam logic [11:0] ADDR_INSN   = 12'h000;
    localparam logic [11:0] ADDR_CONDV  = 12'h004;
    localparam logic [11:0] ADDR_STATUS = 12'h008;
    localparam logic [11:0] ADDR_FIELDS = 12'h00C;
    localparam logic [11:0] ADDR_IMM    = 12'h010;
    localparam logic [15:0] CONDV_RST   = 16'h0000;

    // ************************************************************
    // format numbers
    // ************************************************************
    localparam logic [4:0] FMT_0  = 5'h00;
    localparam logic [4:0] FMT_1  = 5'h01;
    localparam logic [4:0] FMT_2  = 5'h02;
    localparam logic [4:0] FMT_3  = 5'h03;
    localparam logic [4:0] FMT_4  = 5'h04;
    localparam logic [4:0] FMT_5  = 5'h05;
    localparam logic [4:0] FMT_6  = 5'h06;
    localparam logic [4:0] FMT_7  = 5'h07;
    localparam logic [4:0] FMT_8  = 5'h08;
    localparam logic [4:0] FMT_9  = 5'h09;
    localparam logic [4:0] FMT_10 = 5'h0A;
    localparam logic [4:0] FMT_11 = 5'h0B;
    localparam logic [4:0] FMT_12 = 5'h0C;
    localparam logic [4:0] FMT_13 = 5'h0D;
    localparam logic [4:0] FMT_14 = 5'h0E;
    localparam logic [4:0] FMT_15 = 5'h0F;
    localparam logic [4:0] FMT_16 = 5'h10;
    localparam logic [4:0] FMT_17 = 5'h11;
    localparam logic [4:0] FMT_18 = 5'h12;
    localparam logic [4:0] FMT_19 = 5'h13;

    // ************************************************************
    // first-byte patterns
    // ************************************************************
    localparam logic [3:0] LOW_F0   = 4'hA;
    localparam logic [3:0] LOW_F1   = 4'h2;
    localparam logic [3:0] LOW_EXT  = 4'hE;
    localparam logic [3:0] LOW_ACU  = 4'h6;
    localparam logic [4:0] LOW_F15  = 5'h16;
    localparam logic [5:0] LOW_F8   = 6'h2E;
    localparam logic [1:0] SEL_F2F3 = 2'h3;
    localparam logic [2:0] SEL_F3   = 3'h7;
    localparam logic [7:0] B_F5  = 8'h0E;
    localparam logic [7:0] B_F6  = 8'h4E;
    localparam logic [7:0] B_F7  = 8'hCE;
    localparam logic [7:0] B_F9  = 8'h3E;
    localparam logic [7:0] B_F10 = 8'h7E;
    localparam logic [7:0] B_F11 = 8'hBE;
    localparam logic [7:0] B_F12 = 8'hFE;
    localparam logic [7:0] B_F13 = 8'h9E;
    localparam logic [7:0] B_F14 = 8'h1E;
    localparam logic [7:0] B_F16 = 8'h5E;
    localparam logic [7:0] B_F17 = 8'hDE;
    localparam logic [7:0] B_F18 = 8'h8E;

    // ************************************************************
    // field codes
    // ************************************************************
    localparam logic [1:0] ILEN_BYTE  = 2'h0;
    localparam logic [1:0] ILEN_WORD  = 2'h1;
    localparam logic [1:0] ILEN_BAD   = 2'h2;
    localparam logic [1:0] ILEN_DWORD = 2'h3;
    localparam logic [2:0] BYTES_1    = 3'h1;
    localparam logic [2:0] BYTES_2    = 3'h2;
    localparam logic [2:0] BYTES_4    = 3'h4;
    localparam logic [6:0] FWIDTH_STD  = 7'h20;
    localparam logic [6:0] FWIDTH_LONG = 7'h40;
    localparam logic [3:0] COND_NEVER  = 4'hF;
    localparam logic [1:0] TERM_BAD    = 2'h2;
    localparam logic [2:0] Q_ADD  = 3'h0;
    localparam logic [2:0] Q_CMP  = 3'h1;
    localparam logic [2:0] Q_STR  = 3'h2;
    localparam logic [2:0] Q_SCND = 3'h3;
    localparam logic [2:0] Q_ACB  = 3'h4;
    localparam logic [2:0] Q_MOV  = 3'h5;
    localparam logic [2:0] Q_LD   = 3'h6;
    localparam logic [3:0] F3_BAD = 4'h8;
    localparam logic [2:0] F8_MOVE_SPACE = 3'h6;
    localparam logic [2:0] REG_SU = 3'h1;
    localparam logic [2:0] REG_US = 3'h3;
    localparam logic [15:0] CPU_REG_OK = 16'hE701;
    localparam logic [15:0] MMU_REG_OK = 16'hBC03;
    localparam logic [15:0] F3_OK   = 16'h5455;
    localparam logic [15:0] F5_OK   = 16'h000F;
    localparam logic [15:0] F6_OK   = 16'hFBEF;
    localparam logic [15:0] F7_OK   = 16'hFBFF;
    localparam logic [15:0] FARI_OK = 16'h333F;
    localparam logic [15:0] F14_OK  = 16'h000F;
    localparam logic [15:0] C0_OK   = 16'h0C03;
    localparam logic [7:0]  ACU_OK  = 8'h23;

    typedef struct packed {
        logic [4:0]  fmt;
        logic [3:0]  op;
        logic [2:0]  ibytes;
        logic [6:0]  fwidth;
        logic [3:0]  cond;
        logic        cond_met;
        logic [31:0] imm;
        logic [3:0]  regsel;
        logic        str_xlate;
        logic        str_back;
        logic [1:0]  str_term;
        logic        trap;
    } dec_t;

endpackage : insn_decode_pkg

//--- verilog/insn_decode.sv
/*
 Instruction format decoder with an APB register slave. Software writes
 a 32-bit instruction word (first byte in bits 7:0); the decoder then
 publishes format, operation, operand and option fields, and pulses
 either an execute permit or the illegal-opcode trap request.
 Assumes an APB master on CLK and a synchronous active-high RESET.
*/
`timescale 1ns/10ps

// Function
// RULE1: integer length code 00 byte, 01 word, 11 double word.
// RULE2: floating field one selects 32-bit, zero selects 64-bit precision.
// RULE3: condition code 1111 is never satisfied, whatever the flags.
// RULE4: quick move, add, compare and add-compare-branch sign-extend short.
// RULE5: cpu register select codes decoded; other codes reserved.
// RULE6: string short field gives translate, backward and termination code.
// RULE7: mmu register numbers decoded; other codes reserved.
// RULE8: low nibble 0010 one-byte control format, op in high nibble.
// RULE9: single-operand format traps on odd codes and on 1000.
// RULE10: string format decodes 0000 to 0011; 1XXX and 01XX trap.
// RULE11: first byte 01001110 decodes; codes 0100 and 1010 trap.
// RULE12: extended arithmetic decodes four-bit code; 1010 traps.
// RULE13: field format op 110 with reg 001 or 011 moves between spaces.
// RULE14: floating conversion decodes all eight three-bit codes.
// RULE15: floating arithmetic traps on 0110, 0111, 1010, 1011, 1110, 1111.
// RULE16: custom selector 010, 011, 100, 110, 111 always traps.
// RULE17: custom sub-format zero allows 0000, 0001, 1010, 1011 only.
// RULE18: custom sub-format five traps on the same six codes.
// RULE19: unassigned formats ten, twelve, thirteen, sixteen-nineteen always trap.
// RULE20: any reserved encoding suppresses execution and raises one trap.
module insn_decode
    import insn_decode_pkg::*;
(
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        RESET,
    // apb slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // decode results
    output logic             DECODE_VALID,
    output logic             EXEC_PERMIT,
    output logic             TRAP_REQ
);

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic [31:0] insn;
        logic [15:0] condv;
        logic        pend;
        dec_t        dec;
        logic        valid;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        exec_p;
        logic        trap_p;
    } state_t;

    state_t state_reg;
    state_t state_next;

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [2:0] int_bytes(input logic [1:0] code);
        case (code)
            ILEN_BYTE:  int_bytes = BYTES_1; // RULE1
            ILEN_WORD:  int_bytes = BYTES_2; // RULE1
            ILEN_DWORD: int_bytes = BYTES_4; // RULE1
            // code 10 names no length; callers trap it, except formats 2, 3, 4 and custom sub-format five
            default:    int_bytes = '0;
        endcase
    endfunction : int_bytes

    function automatic logic [6:0] flt_width(input logic f);
        flt_width = f ? FWIDTH_STD : FWIDTH_LONG; // RULE2
    endfunction : flt_width

    function automatic logic cond_eval(input logic [3:0] c,
                                       input logic [15:0] cv);
        // condition vector is supplied by software, one bit per code
        cond_eval = (c != COND_NEVER) && cv[c]; // RULE3
    endfunction : cond_eval

    // ************************************************************
    // decode
    // ************************************************************
    function automatic dec_t decode(input logic [31:0] w,
                                    input logic [15:0] cv);
        dec_t       d;
        logic [3:0] op4;
        logic [3:0] sh;
        logic       ibad;
        d    = '0;
        op4  = w[13:10];
        sh   = w[18:15];
        ibad = (w[9:8] == ILEN_BAD);
        if (w[3:0] == LOW_F0) begin
            d.fmt      = FMT_0;
            d.cond     = w[7:4];
            d.cond_met = cond_eval(w[7:4], cv);
        end
        else if (w[3:0] == LOW_F1) begin
            d.fmt = FMT_1; // RULE8
            d.op  = w[7:4]; // RULE8
        end
        else if (w[3:0] == LOW_EXT) begin
            d.ibytes = int_bytes(w[9:8]);
            d.op     = op4;
            if (w[5:0] == LOW_F8) begin
                d.fmt = FMT_8;
                d.op  = {1'b0, w[10], w[7:6]};
                d.regsel = {1'b0, w[13:11]};
                // only the space moves give the register field a meaning of its own
                if ({w[10], w[7:6]} == F8_MOVE_SPACE)
                begin
                    d.trap = (w[13:11] != REG_SU) && (w[13:11] != REG_US); // RULE13
                end
                else
                begin
                    d.trap = (d.op[2:0] == SEL_F3);
                end
                d.trap = d.trap || ibad;
            end
            else begin
                case (w[7:0])
                    B_F5:
                    begin
                        d.fmt       = FMT_5;
                        d.str_xlate = sh[0]; // RULE6
                        d.str_back  = sh[1]; // RULE6
                        d.str_term  = sh[3:2]; // RULE6
                        d.trap      = !F5_OK[op4] || ibad; // RULE10
                        // configuration writes carry no termination code
                        if (op4 != 4'h2)
                        begin
                            d.trap = d.trap || (sh[3:2] == TERM_BAD);
                        end
                    end
                    B_F6:
                    begin
                        d.fmt  = FMT_6;
                        d.trap = !F6_OK[op4] || ibad; // RULE11
                    end
                    B_F7:
                    begin
                        d.fmt  = FMT_7;
                        d.trap = !F7_OK[op4] || ibad; // RULE12
                    end
                    B_F9:
                    begin
                        d.fmt    = FMT_9;
                        d.op     = {1'b0, w[13:11]}; // RULE14
                        d.fwidth = flt_width(w[10]);
                        d.trap   = ibad;
                    end
                    B_F11:
                    begin
                        d.fmt    = FMT_11;
                        d.ibytes = '0;
                        d.fwidth = flt_width(w[8]);
                        d.trap   = !FARI_OK[op4] || w[9]; // RULE15
                    end
                    B_F14:
                    begin
                        d.fmt    = FMT_14;
                        d.regsel = sh;
                        d.trap   = !F14_OK[op4] || ibad;
                        if (op4[3:1] == 3'h1)
                        begin
                            d.trap = d.trap || !MMU_REG_OK[sh]; // RULE7
                        end
                    end
                    B_F10:   d.fmt = FMT_10;
                    B_F12:   d.fmt = FMT_12;
                    B_F13:   d.fmt = FMT_13;
                    B_F16:   d.fmt = FMT_16;
                    B_F17:   d.fmt = FMT_17;
                    default: d.fmt = FMT_18;
                endcase
                case (d.fmt)
                    FMT_10, FMT_12, FMT_13, FMT_16, FMT_17, FMT_18:
                    begin
                        d.ibytes = '0;
                        d.op     = '0;
                        d.trap   = 1'b1; // RULE19
                    end
                    default: ;
                endcase
            end
        end
        else if (w[4:0] == LOW_F15) begin
            d.fmt    = FMT_15;
            d.regsel = {1'b0, w[7:5]};
            d.ibytes = int_bytes(w[9:8]);
            d.op     = op4;
            case (w[7:5])
                3'h0:
                begin
                    d.trap = !C0_OK[op4] || ibad; // RULE17
                end
                3'h1:
                begin
                    d.op     = {1'b0, w[13:11]};
                    d.fwidth = flt_width(w[10]); // RULE2
                    d.trap   = ibad;
                end
                3'h5:
                begin
                    d.fwidth = flt_width(w[8]); // RULE2
                    d.trap   = !FARI_OK[op4]; // RULE18
                end
                default:
                begin
                    d.trap = 1'b1;
                end
            endcase
            // selector check kept apart so it holds whatever the case above did
            d.trap = d.trap || !ACU_OK[w[7:5]]; // RULE16
        end
        else if (w[3:0] == LOW_ACU) begin
            d.fmt  = FMT_19;
            d.trap = 1'b1; // RULE19
        end
        else if (w[3:2] == SEL_F2F3) begin
            d.ibytes = int_bytes(w[1:0]);
            if (w[6:4] == SEL_F3) begin
                d.fmt  = FMT_3;
                d.op   = w[10:7];
                d.trap = !F3_OK[w[10:7]] || (w[10:7] == F3_BAD); // RULE9
            end
            else begin
                d.fmt = FMT_2;
                d.op  = {1'b0, w[6:4]};
                case (w[6:4])
                    Q_ADD, Q_CMP, Q_ACB, Q_MOV:
                    begin
                        d.imm = {{28{w[10]}}, w[10:7]}; // RULE4
                    end
                    Q_SCND:
                    begin
                        d.cond     = w[10:7];
                        d.cond_met = cond_eval(w[10:7], cv);
                    end
                    Q_STR, Q_LD:
                    begin
                        d.regsel = w[10:7];
                        d.trap   = !CPU_REG_OK[w[10:7]]; // RULE5
                    end
                    default: ;
                endcase
            end
        end
        else begin
            d.fmt    = FMT_4;
            d.op     = w[5:2];
            d.ibytes = int_bytes(w[1:0]);
        end
        decode = d;
    endfunction : decode

    // ************************************************************
    // next state
    // ************************************************************
    always_comb
    begin
        logic        mapped;
        logic [31:0] rd;
        state_next = state_reg;
        mapped     = 1'b1;
        rd         = '0;
        state_next.exec_p  = 1'b0;
        state_next.trap_p  = 1'b0;
        state_next.pend    = 1'b0;
        state_next.pready  = 1'b0;
        state_next.pslverr = 1'b0;

        // one decode per instruction write; trap and permit exclusive
        if (state_reg.pend) begin
            state_next.dec    = decode(state_reg.insn, state_reg.condv);
            state_next.valid  = 1'b1;
            state_next.trap_p = state_next.dec.trap; // RULE20
            state_next.exec_p = !state_next.dec.trap; // RULE20
        end

        case (PADDR)
            ADDR_INSN:   rd = state_reg.insn;
            ADDR_CONDV:  rd = {16'h0000, state_reg.condv};
            ADDR_STATUS: rd = {16'h0000,
                               3'h0,
                               state_reg.dec.cond_met,
                               state_reg.dec.op,
                               state_reg.dec.fmt,
                               state_reg.dec.trap,
                               state_reg.pend,
                               state_reg.valid};
            ADDR_FIELDS: rd = {6'h00,
                               state_reg.dec.str_term,
                               state_reg.dec.str_back,
                               state_reg.dec.str_xlate,
                               state_reg.dec.regsel,
                               state_reg.dec.cond,
                               state_reg.dec.fwidth,
                               state_reg.dec.ibytes,
                               4'h0};
            ADDR_IMM:    rd = state_reg.dec.imm;
            default:     mapped = 1'b0;
        endcase

        // setup phase: answer is ready in the first access cycle
        if (PSEL && !PENABLE) begin
            state_next.pready  = 1'b1;
            state_next.pslverr = !mapped;
            state_next.prdata  = PWRITE ? '0 : rd;
        end

        // access phase completion
        if (PSEL && PENABLE && state_reg.pready) begin
            state_next.prdata = '0;
            if (PWRITE && !state_reg.pslverr) begin
                case (PADDR)
                    ADDR_INSN:
                    begin
                        state_next.insn  = PWDATA;
                        state_next.pend  = 1'b1;
                        state_next.valid = 1'b0;
                    end
                    ADDR_CONDV:
                    begin
                        state_next.condv = PWDATA[15:0];
                    end
                    default: ;
                endcase
            end
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge CLK)
    begin
        if (RESET) begin
            state_reg       <= '0;
            state_reg.condv <= CONDV_RST;
        end
        else begin
            state_reg <= state_next;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign PRDATA       = state_reg.prdata;
    assign PREADY       = state_reg.pready;
    assign PSLVERR      = state_reg.pslverr;
    assign DECODE_VALID = state_reg.valid;
    assign EXEC_PERMIT  = state_reg.exec_p;
    assign TRAP_REQ     = state_reg.trap_p;

endmodule : insn_decode

//--- verif/insn_decode_checker.sv
/*
 checker: apb handshake and decode pulse relations of the decoder.
 assumes a bind to insn_decode; sees only its ports.
*/
`timescale 1ns/10ps
module insn_decode_checker
    import insn_decode_pkg::*;
(
    // clock, reset and apb
    input wire logic        CLK, RESET, PSEL, PENABLE, PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA, PRDATA,
    input wire logic        PREADY, PSLVERR,
    // decode results
    input wire logic        DECODE_VALID, EXEC_PERMIT, TRAP_REQ
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);
    wire setup   = PSEL && !PENABLE;
    wire wr_insn = PSEL && PENABLE && PREADY && PWRITE && PADDR == ADDR_INSN;
    // a restarted decode still ends two edges after its last write
    wire pulse   = EXEC_PERMIT || TRAP_REQ;
    ready_next_a: assert property (setup |=> PREADY)
        else $error("no ready after setup");
    ready_once_a: assert property (PREADY |=> !PREADY)
        else $error("ready longer than one cycle");
    idle_data_a: assert property (!PREADY |-> PRDATA == 32'h0)
        else $error("read data outside access");
    unmap_err_a: assert property (setup && PADDR > ADDR_IMM |=> PSLVERR && PRDATA == 32'h0)
        else $error("unmapped access not refused");
    map_ok_a: assert property (setup && PADDR <= ADDR_IMM && PADDR[1:0] == 2'h0 |=> !PSLVERR)
        else $error("mapped access refused");
    one_kind_a: assert property (!(EXEC_PERMIT && TRAP_REQ))
        else $error("permit and trap together");
    trap_once_a: assert property (TRAP_REQ |=> !TRAP_REQ)
        else $error("trap longer than one cycle");
    decode_walk_a: assert property (wr_insn |=> !DECODE_VALID ##1 (DECODE_VALID && pulse))
        else $error("decode result late or missing");
    pulse_cause_a: assert property (pulse |-> $past(wr_insn, 2))
        else $error("result pulse without instruction");
    cover property (TRAP_REQ);
    cover property (EXEC_PERMIT);
    cover property (PSLVERR);
endmodule : insn_decode_checker

bind insn_decode insn_decode_checker insn_decode_checker_i (
    .CLK(CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .DECODE_VALID(DECODE_VALID), .EXEC_PERMIT(EXEC_PERMIT),
    .TRAP_REQ(TRAP_REQ));

//--- verif/exec_ctrl_model.sv
/*
 execution control model: tallies legal and trapped instructions.
 assumes one-cycle result pulses on the decoder clock.
*/
`timescale 1ns/10ps
module exec_ctrl_model
(
    // clock, reset and decode results
    input  wire logic clk, reset, permit, trap,
    // tallies since reset
    output int        n_permit, n_trap, n_both
);
    // a trapped instruction must never also start executing
    always @(posedge clk)
    begin
        n_permit <= reset ? 0 : n_permit + int'(permit === 1'b1);
        n_trap   <= reset ? 0 : n_trap + int'(trap === 1'b1);
        n_both   <= reset ? 0 : n_both + int'(permit === 1'b1 && trap === 1'b1);
    end
endmodule : exec_ctrl_model

//--- verif/insn_decode_test.sv
/*
 bench for insn_decode: apb register access, decode tables, random quick values.
 assumes the package, the checker bind and exec_ctrl_model.
*/
`timescale 1ns/10ps
module insn_decode_test
    import insn_decode_pkg::*;
;
    logic        clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, st, fl, im, r;
    logic        pready, pslverr, dvalid, permit, trap, er;
    logic [3:0]  s;
    logic [2:0]  op;
    logic [1:0]  ln;
    int          fails = 0, n_checks = 0, n_permit, n_trap, n_both;
    int          exp_q[$];
    // trap, format, instruction word
    logic [43:0] vec[$] = '{
        44'h0_01_00000032, 44'h0_01_000000B2, 44'h0_00_000000FA, 44'h0_03_0000067F,
        44'h1_03_0000047F, 44'h1_03_000000FF, 44'h0_02_000006EF, 44'h1_02_000005EF,
        44'h1_02_000000AF, 44'h0_02_0000002F, 44'h0_05_0007800E, 44'h0_05_0002000E,
        44'h1_05_0004000E, 44'h1_05_0000100E, 44'h1_05_0000200E, 44'h0_05_0000080E,
        44'h1_06_0000134E, 44'h1_06_00002B4E, 44'h0_06_00000F4E, 44'h0_06_00002F4E,
        44'h0_07_000023CE, 44'h1_07_00002BCE, 44'h1_07_000022CE, 44'h0_08_00000FAE,
        44'h0_08_00001FAE, 44'h1_08_000017AE, 44'h0_09_00003F3E, 44'h0_09_0000233E,
        44'h0_0B_000001BE, 44'h0_0B_000020BE, 44'h1_0B_000018BE, 44'h1_0B_00003CBE,
        44'h1_0A_0000007E, 44'h1_0C_000000FE, 44'h1_0D_0000009E, 44'h1_10_0000005E,
        44'h1_11_000000DE, 44'h1_12_0000008E, 44'h1_13_00000006, 44'h0_0E_00058B1E,
        44'h1_0E_00010B1E, 44'h0_0E_00078B1E, 44'h0_0F_00002B16, 44'h1_0F_00000B16,
        44'h0_0F_00000716, 44'h1_0F_00001BB6, 44'h0_0F_000023B6, 44'h1_0F_00000056,
        44'h1_0F_00000076, 44'h1_0F_00000096, 44'h1_0F_000000D6, 44'h1_0F_000000F6};

    insn_decode insn_decode_i (.CLK(clk), .RESET(reset), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .DECODE_VALID(dvalid), .EXEC_PERMIT(permit), .TRAP_REQ(trap));
    exec_ctrl_model exec_ctrl_model_i (.clk(clk), .reset(reset), .permit(permit), .trap(trap),
        .n_permit(n_permit), .n_trap(n_trap), .n_both(n_both));

    always #12.5 clk = ~clk;

    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("Error %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk

    // one transfer; request held until ready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic decode(input logic [31:0] w, input logic t);
        apb(1'b1, ADDR_INSN, w);
        @(posedge clk);
        chk("early", {dvalid, permit, trap}, 32'h0);
        @(posedge clk);
        chk("result", {dvalid, permit, trap}, {29'h0, 1'b1, !t, t});
        exp_q.push_back(int'(t));
        apb(1'b0, ADDR_STATUS, 32'h0);
        st = rd;
        apb(1'b0, ADDR_FIELDS, 32'h0);
        fl = rd;
        apb(1'b0, ADDR_IMM, 32'h0);
        im = rd;
    endtask : decode

    // legal word; compare n bits at lo of status (sel) or fields
    task automatic probe(input logic [31:0] w, input bit sel, input int lo, input int n,
                         input logic [31:0] e);
        decode(w, 1'b0);
        chk("field", ((sel ? st : fl) >> lo) & ((32'h1 << n) - 32'h1), e);
    endtask : probe

    task automatic wrap_up();
        if (fails == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : wrap_up

    initial
    begin
        void'($urandom(32'hE9AE));
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        apb(1'b0, ADDR_CONDV, 32'h0);
        chk("condv rst", rd, {16'h0, CONDV_RST});
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk("status rst", rd, 32'h0);
        apb(1'b1, ADDR_STATUS, 32'hFFFFFFFF);
        chk("ro err", {31'h0, er}, 32'h0);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk("ro keep", rd, 32'h0);
        apb(1'b0, 12'h014, 32'h0);
        chk("unmapped", {er, rd[30:0]}, 32'h80000000);
        r = $urandom & 32'h7FFF;
        apb(1'b1, ADDR_CONDV, r);
        apb(1'b0, ADDR_CONDV, 32'h0);
        chk("condv rw", rd, r);
        // every code satisfied, so only the never code can read false
        apb(1'b1, ADDR_CONDV, 32'h0000FFFF);
        foreach (vec[i])
        begin
            decode(vec[i][31:0], vec[i][40]);
            chk("status", st[7:2], {vec[i][36:32], vec[i][40]});
        end
        probe(32'h000000FA, 1, 12, 1, 32'h0);
        probe(32'h000000EA, 1, 12, 1, 32'h1);
        probe(32'h000006EF, 0, 18, 4, 32'hD);
        probe(32'h00078B1E, 0, 18, 4, 32'hF);
        probe(32'h0007800E, 0, 22, 4, 32'hF);
        probe(32'h0002000E, 0, 22, 4, 32'h4);
        probe(32'h00003F3E, 0, 7, 7, FWIDTH_STD);
        probe(32'h000020BE, 0, 7, 7, FWIDTH_LONG);
        probe(32'h000000B2, 1, 8, 4, 32'hB);
        probe(32'h000023CE, 1, 8, 4, 32'h8);
        for (int k = 0; k < 8; k++)
        begin
            s  = 4'($urandom);
            op = {1'($urandom), 1'b0, 1'($urandom)};
            ln = 1'($urandom) ? 2'h3 : 2'($urandom % 2);
            decode({21'h0, s, op, 2'h3, ln}, 1'b0);
            chk("imm", im, {{28{s[3]}}, s});
            chk("len", fl[6:4], (ln == 2'h0) ? 32'h1 : (ln == 2'h1) ? 32'h2 : 32'h4);
        end
        chk("traps", n_trap, exp_q.sum());
        chk("permits", n_permit, exp_q.size() - exp_q.sum());
        chk("both", n_both, 32'h0);
        wrap_up();
    end

    // a full run takes about 1000 cycles
    initial
    begin
        repeat (8000) @(posedge clk);
        fails++;
        wrap_up();
    end
endmodule : insn_decode_test
